// [logic/sbcd_pkg.sv]
`default_nettype none
package sbcd_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IO_PINS = 3;
  localparam int unsigned RESULT_W = 10;
  localparam logic [ADDR_W-1:0] GLOBAL_ADDR = 4'h0;
  localparam logic [4:0] LONG_BITS = 5'h10;
  localparam logic [4:0] SHORT_CMD_BITS = 5'h08;
  localparam logic [4:0] SHORT_LEN_STD = 5'h08;
  localparam logic [4:0] SHORT_LEN_ALT = 5'h0a;

  typedef enum logic [3:0] {
    SBCD_CMD_INIT = 4'h0, SBCD_CMD_STATUS = 4'h1, SBCD_CMD_SENSE0 = 4'h2, SBCD_CMD_IOCTL = 4'h3,
    SBCD_CMD_ID = 4'h4, SBCD_CMD_SENSE1 = 4'h5, SBCD_CMD_CLEAR = 4'h7, SBCD_CMD_FORMAT = 4'ha
  } sbcd_cmd_type;

  // format control register pointers and standard-bus defaults
  localparam logic [2:0] FMT_POLY_IDX = 3'h0;
  localparam logic [2:0] FMT_SEED_IDX = 3'h2;
  localparam logic [2:0] FMT_SWLEN_IDX = 3'h5;
  localparam logic [2:0] FMT_SEL_IDX = 3'h7;
  localparam logic [3:0] STD_POLY = 4'h1;
  localparam logic [3:0] STD_SEED = 4'ha;
  localparam logic [3:0] STD_SWLEN = 4'h8;
  localparam logic [3:0] ALT_SWLEN = 4'ha;
  localparam logic [3:0] SEL_ON = 4'hf;
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [7:0][3:0] FMT_DEFAULTS = {SEL_OFF, 4'h0, STD_SWLEN, 4'h0, 4'h0, STD_SEED, 4'h0, STD_POLY};

  typedef struct packed {logic [DATA_W-1:0] data; logic [ADDR_W-1:0] addr; sbcd_cmd_type cmd;} sbcd_frame_type;
  typedef struct packed {logic [ADDR_W-1:0] addr; logic [3:0] pad; logic [DATA_W-1:0] data;} sbcd_rsp_type;
  typedef struct packed {logic rsv; logic upper; logic lower; logic jitter; logic [3:0] node;} sbcd_init_type;
  typedef struct packed {logic rsv; logic [2:0] level; logic rsv2; logic [2:0] dir;} sbcd_ioctl_type;
  typedef struct packed {logic rsv; logic upper; logic lower; logic [1:0] rsv2; logic [2:0] pins;} sbcd_stat_type;
  typedef struct packed {logic [3:0] issue; logic [2:0] rsv; logic flag;} sbcd_id_type;
  typedef struct packed {logic rw; logic [2:0] ptr; logic [3:0] val;} sbcd_fmt_type;

  // controller register map, byte offsets
  localparam logic [3:0] CTL_CMD_OFS = 4'h0;
  localparam logic [3:0] CTL_STAT_OFS = 4'h4;
  localparam logic [3:0] CTL_RSP_OFS = 4'h8;
  localparam logic [3:0] CTL_CFG_OFS = 4'hc;
  localparam logic [7:0] RSP_WAIT_CYCLES = 8'h08;
  typedef struct packed {logic [14:0] rsv; logic is_long; logic [15:0] frame;} sbcd_cmd_reg_type;
  typedef struct packed {logic [27:0] rsv; logic rsp_long; logic rsp_err; logic rsp_got; logic busy;} sbcd_stat_reg_type;
  typedef struct packed {logic [11:0] rsv; logic [3:0] crc; logic [15:0] frame;} sbcd_rsp_reg_type;
  typedef struct packed {logic [19:0] rsv; logic [3:0] swlen; logic [3:0] seed; logic [3:0] poly;} sbcd_cfg_reg_type;

  // bit-serial crc over the low n bits, msb first; x^4 term is implicit
  function automatic logic [3:0] sbcd_crc4(logic [15:0] bits, logic [4:0] n, logic [3:0] poly, logic [3:0] seed);
    logic [3:0] c;
    logic fb;
    c = seed;
    fb = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (i < int'(n)) begin
        fb = c[3] ^ bits[i];
        c = {c[2:0], 1'b0} ^ (fb ? poly : 4'h0);
      end
    end
    return c;
  endfunction : sbcd_crc4
endpackage : sbcd_pkg
`default_nettype wire

// [logic/sbcd_link_if.sv]
`default_nettype none
interface sbcd_link_if;
  logic cmd_valid; // one-cycle frame strobe
  logic cmd_long; // 1 long frame, 0 short frame
  logic [15:0] cmd_frame; // data, address, command
  logic [3:0] cmd_crc; // trailing crc
  logic rsp_valid;
  logic rsp_long;
  logic [15:0] rsp_frame;
  logic [3:0] rsp_crc;
  modport dev (input cmd_valid, cmd_long, cmd_frame, cmd_crc, output rsp_valid, rsp_long, rsp_frame, rsp_crc);
  modport ctl (output cmd_valid, cmd_long, cmd_frame, cmd_crc, input rsp_valid, rsp_long, rsp_frame, rsp_crc);
endinterface : sbcd_link_if
`default_nettype wire

// [logic/sbcd_sensor_node.sv]
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`default_nettype none
// Overview of operation
// RL1: every frame ends with four-bit crc
// RL2: init closes upper switch when bit set
// RL3: init closes lower switch when bit set
// RL4: init adopts new node number
// RL5: init jitter bit enables clock dithering
// RL6: pin select bit makes pin output
// RL7: drive vector sets output pin levels
// RL8: format msb: 1 write, 0 read
// RL9: format bits 6..4 select register
// RL10: format low nibble is write value
// RL11: response carries address, zero nibble
// RL12: init/status report switch states
// RL13: status reports sampled pin levels
// RL14: id returns issue and flag
// RL15: format response echoes flag, pointer
// RL16: format response returns register after update
// RL17: clear/reserved silent; others echo or report
// RL18: short responses only for sensor reads
// RL19: global address executes silently
// RL20: reset or clear restores format defaults
module sbcd_sensor_node #(
  parameter logic [3:0] CHIP_ISSUE = 4'h1, // arbitrary value
  parameter logic ID_FLAG = 1'b0, // flag bit of id response
  parameter int unsigned SENSE_W = 10 // sensor result width
) (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic resetn, // synchronous, active low
  sbcd_link_if.dev link, // sensor bus side
  input wire logic [SENSE_W-1:0] sensor_input_0, // conversion result 0
  input wire logic [SENSE_W-1:0] sensor_input_1, // conversion result 1
  input wire logic [sbcd_pkg::IO_PINS-1:0] io_in, // logic pin levels
  output logic [sbcd_pkg::IO_PINS-1:0] io_out, // logic pin drive level
  output logic [sbcd_pkg::IO_PINS-1:0] io_oe, // logic pin drive enable
  output logic upper_switch_close, // high-side switch closed
  output logic lower_switch_close, // low-side switch closed
  output logic clock_jitter_enable, // oscillator dithering
  output logic [sbcd_pkg::ADDR_W-1:0] node_addr // present bus address
);
  import sbcd_pkg::*;

  if (SENSE_W != RESULT_W) begin : g_chk
    $error("sensor result width must be 10");
  end

  typedef struct packed {
    logic [ADDR_W-1:0] node;
    logic upper;
    logic lower;
    logic jitter;
    logic [IO_PINS-1:0] dir;
    logic [IO_PINS-1:0] level;
    logic [7:0][3:0] fmt;
    logic rsp_valid;
    logic rsp_long;
    logic [15:0] rsp_frame;
    logic [3:0] rsp_crc;
  } sbcd_dev_state_type;

  localparam sbcd_dev_state_type DEV_RESET = '{node: GLOBAL_ADDR, upper: 1'b0, lower: 1'b0, jitter: 1'b0,
    dir: '0, level: '0, fmt: FMT_DEFAULTS, rsp_valid: 1'b0, rsp_long: 1'b0, rsp_frame: '0, rsp_crc: '0};

  sbcd_dev_state_type state_reg;
  sbcd_dev_state_type state_next;
  sbcd_frame_type cf;
  sbcd_init_type ic;
  sbcd_ioctl_type ioc;
  sbcd_fmt_type fc;
  logic enhanced;
  logic [3:0] poly;
  logic [3:0] seed;
  logic [4:0] short_len;
  logic [15:0] chk_bits;
  logic [4:0] chk_len;
  logic hit;
  logic send;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  logic [SENSE_W-1:0] result;
  logic [15:0] sdata;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.rsp_valid = 1'b0;
    cf = sbcd_frame_type'(link.cmd_frame);
    ic = sbcd_init_type'(cf.data);
    ioc = sbcd_ioctl_type'(cf.data);
    fc = sbcd_fmt_type'(cf.data);
    // alternate crc and short length apply only once the selection is all ones
    enhanced = (state_reg.fmt[FMT_SEL_IDX] == SEL_ON);
    poly = enhanced ? state_reg.fmt[FMT_POLY_IDX] : STD_POLY;
    seed = enhanced ? state_reg.fmt[FMT_SEED_IDX] : STD_SEED;
    short_len = (enhanced && state_reg.fmt[FMT_SWLEN_IDX] == ALT_SWLEN) ? SHORT_LEN_ALT : SHORT_LEN_STD;
    chk_bits = link.cmd_long ? link.cmd_frame : {{DATA_W{1'b0}}, cf.addr, cf.cmd};
    chk_len = link.cmd_long ? LONG_BITS : SHORT_CMD_BITS;
    // corrupted frames are dropped whole
    hit = link.cmd_valid && (sbcd_crc4(chk_bits, chk_len, poly, seed) == link.cmd_crc) && // see RL1
          (cf.addr == state_reg.node || cf.addr == GLOBAL_ADDR ||
           (state_reg.node == GLOBAL_ADDR && cf.cmd == SBCD_CMD_INIT));
    send = 1'b0;
    raddr = state_reg.node;
    rdata = '0;
    result = (cf.cmd == SBCD_CMD_SENSE1) ? sensor_input_1 : sensor_input_0;
    sdata = (short_len == SHORT_LEN_ALT) ? 16'(result) : 16'(result[SENSE_W-1 -: DATA_W]);
    if (hit) begin
      case (cf.cmd)
        SBCD_CMD_INIT: begin
          if (link.cmd_long) begin
            state_next.upper = ic.upper; // see RL2
            state_next.lower = ic.lower; // see RL3
            state_next.jitter = ic.jitter; // see RL5
            state_next.node = ic.node; // see RL4
            raddr = ic.node;
            rdata = sbcd_init_type'{rsv: 1'b0, upper: ic.upper, lower: ic.lower, jitter: 1'b0, node: ic.node}; // see RL12
            send = 1'b1;
          end
        end
        SBCD_CMD_STATUS: begin
          rdata = sbcd_stat_type'{rsv: 1'b0, upper: state_reg.upper, lower: state_reg.lower, // see RL12
                                  rsv2: 2'h0, pins: io_in}; // see RL13
          send = link.cmd_long; // see RL18
        end
        SBCD_CMD_SENSE0, SBCD_CMD_SENSE1: begin
          rdata = result[SENSE_W-1 -: DATA_W]; // see RL17
          send = 1'b1; // see RL18
        end
        SBCD_CMD_IOCTL: begin
          if (link.cmd_long) begin
            state_next.dir = ioc.dir; // see RL6
            state_next.level = ioc.level; // see RL7
            rdata = sbcd_ioctl_type'{rsv: 1'b0, level: ioc.level, rsv2: 1'b0, dir: ioc.dir}; // see RL17
            send = 1'b1;
          end
        end
        SBCD_CMD_ID: begin
          rdata = sbcd_id_type'{issue: CHIP_ISSUE, rsv: 3'h0, flag: ID_FLAG}; // see RL14
          send = link.cmd_long;
        end
        SBCD_CMD_CLEAR: begin
          state_next.fmt = FMT_DEFAULTS; // see RL20
        end
        SBCD_CMD_FORMAT: begin
          if (link.cmd_long) begin
            if (fc.rw) begin // see RL8
              // in enhanced mode only the return to standard is honoured
              if (enhanced) begin
                if (fc.ptr == FMT_SEL_IDX && fc.val == SEL_OFF) begin
                  state_next.fmt[FMT_SEL_IDX] = SEL_OFF;
                end
              end else begin
                case (fc.ptr) // see RL9
                  FMT_POLY_IDX, FMT_SEED_IDX: begin
                    state_next.fmt[fc.ptr] = fc.val; // see RL10
                  end
                  FMT_SWLEN_IDX: begin
                    if (fc.val == STD_SWLEN || fc.val == ALT_SWLEN) begin
                      state_next.fmt[fc.ptr] = fc.val;
                    end
                  end
                  FMT_SEL_IDX: begin
                    // partial patterns leave the mode alone
                    if (fc.val == SEL_ON || fc.val == SEL_OFF) begin
                      state_next.fmt[fc.ptr] = fc.val;
                    end
                  end
                  default: begin
                  end
                endcase
              end
            end
            rdata = {fc.rw, fc.ptr, state_next.fmt[fc.ptr]}; // see RL15 see RL16
            send = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (send && cf.addr != GLOBAL_ADDR) begin // see RL19
      state_next.rsp_valid = 1'b1;
      state_next.rsp_long = link.cmd_long;
      if (link.cmd_long) begin
        state_next.rsp_frame = sbcd_rsp_type'{addr: raddr, pad: 4'h0, data: rdata}; // see RL11
        state_next.rsp_crc = sbcd_crc4(state_next.rsp_frame, LONG_BITS, poly, seed); // see RL1
      end else begin
        state_next.rsp_frame = sdata;
        state_next.rsp_crc = sbcd_crc4(sdata, short_len, poly, seed);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= DEV_RESET; // see RL20
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.rsp_valid = state_reg.rsp_valid;
  assign link.rsp_long = state_reg.rsp_long;
  assign link.rsp_frame = state_reg.rsp_frame;
  assign link.rsp_crc = state_reg.rsp_crc;
  assign io_out = state_reg.level;
  assign io_oe = state_reg.dir;
  assign upper_switch_close = state_reg.upper;
  assign lower_switch_close = state_reg.lower;
  assign clock_jitter_enable = state_reg.jitter;
  assign node_addr = state_reg.node;
endmodule : sbcd_sensor_node
`default_nettype wire

// [logic/sbcd_bus_controller.sv]
`default_nettype none
module sbcd_bus_controller (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic resetn, // synchronous, active low
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  sbcd_link_if.ctl link // sensor bus side
);
  import sbcd_pkg::*;

  typedef enum logic [1:0] {SBCD_IDLE = 2'b00, SBCD_WAIT = 2'b01} sbcd_ctl_st_type;

  typedef struct packed {
    sbcd_ctl_st_type st;
    logic cmd_valid;
    logic cmd_long;
    logic [15:0] cmd_frame;
    logic [3:0] cmd_crc;
    logic [7:0] timer;
    logic rsp_got;
    logic rsp_err;
    logic rsp_long;
    logic [15:0] rsp_frame;
    logic [3:0] rsp_crc;
    sbcd_cfg_reg_type cfg;
    logic rd_ack;
    logic [31:0] readdata;
  } sbcd_ctl_state_type;

  localparam sbcd_cfg_reg_type CFG_RESET = '{rsv: '0, swlen: STD_SWLEN, seed: STD_SEED, poly: STD_POLY};
  localparam sbcd_ctl_state_type CTL_RESET = '{st: SBCD_IDLE, cmd_valid: 1'b0, cmd_long: 1'b0, cmd_frame: '0,
    cmd_crc: '0, timer: '0, rsp_got: 1'b0, rsp_err: 1'b0, rsp_long: 1'b0, rsp_frame: '0, rsp_crc: '0,
    cfg: CFG_RESET, rd_ack: 1'b0, readdata: '0};

  sbcd_ctl_state_type state_reg;
  sbcd_ctl_state_type state_next;
  sbcd_cmd_reg_type wcmd;
  logic busy;
  logic wr_take;
  logic [4:0] short_len;
  logic [4:0] rlen;

  assign busy = (state_reg.st != SBCD_IDLE) || state_reg.cmd_valid;
  // a new command waits until the previous exchange has ended
  assign avs_waitrequest = (avs_read && !state_reg.rd_ack) || (avs_write && avs_address == CTL_CMD_OFS && busy);
  assign wr_take = avs_write && !avs_waitrequest;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.cmd_valid = 1'b0;
    wcmd = sbcd_cmd_reg_type'(avs_writedata);
    short_len = (state_reg.cfg.swlen == ALT_SWLEN) ? SHORT_LEN_ALT : SHORT_LEN_STD;
    rlen = link.rsp_long ? LONG_BITS : short_len;
    state_next.rd_ack = avs_read && !state_reg.rd_ack;
    if (avs_read && !state_reg.rd_ack) begin
      if (avs_address == CTL_CMD_OFS) begin
        state_next.readdata = sbcd_cmd_reg_type'{rsv: '0, is_long: state_reg.cmd_long, frame: state_reg.cmd_frame};
      end else if (avs_address == CTL_STAT_OFS) begin
        state_next.readdata = sbcd_stat_reg_type'{rsv: '0, rsp_long: state_reg.rsp_long, rsp_err: state_reg.rsp_err,
                                                  rsp_got: state_reg.rsp_got, busy: busy};
      end else if (avs_address == CTL_RSP_OFS) begin
        state_next.readdata = sbcd_rsp_reg_type'{rsv: '0, crc: state_reg.rsp_crc, frame: state_reg.rsp_frame};
      end else if (avs_address == CTL_CFG_OFS) begin
        state_next.readdata = 32'(state_reg.cfg);
      end else begin
        state_next.readdata = '0;
      end
    end
    if (wr_take && avs_address == CTL_CFG_OFS) begin
      state_next.cfg = sbcd_cfg_reg_type'(avs_writedata);
      state_next.cfg.rsv = '0;
    end
    case (state_reg.st)
      SBCD_IDLE: begin
        if (wr_take && avs_address == CTL_CMD_OFS) begin
          state_next.cmd_valid = 1'b1;
          state_next.cmd_long = wcmd.is_long;
          state_next.cmd_frame = wcmd.is_long ? wcmd.frame : {{DATA_W{1'b0}}, wcmd.frame[7:0]};
          state_next.cmd_crc = sbcd_crc4(state_next.cmd_frame, wcmd.is_long ? LONG_BITS : SHORT_CMD_BITS,
                                         state_reg.cfg.poly, state_reg.cfg.seed); // see RL1
          state_next.rsp_got = 1'b0;
          state_next.rsp_err = 1'b0;
          state_next.timer = '0;
          state_next.st = SBCD_WAIT;
        end
      end
      SBCD_WAIT: begin
        // silent commands end on the timeout rather than hanging the bus
        if (link.rsp_valid) begin
          state_next.rsp_got = 1'b1;
          state_next.rsp_long = link.rsp_long;
          state_next.rsp_frame = link.rsp_frame;
          state_next.rsp_crc = link.rsp_crc;
          state_next.rsp_err = sbcd_crc4(link.rsp_frame, rlen, state_reg.cfg.poly, state_reg.cfg.seed) !=
                               link.rsp_crc; // see RL1
          state_next.st = SBCD_IDLE;
        end else if (state_reg.timer == RSP_WAIT_CYCLES) begin
          state_next.st = SBCD_IDLE;
        end else begin
          state_next.timer = state_reg.timer + 8'h01;
        end
      end
      default: begin
        state_next.st = SBCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= CTL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign avs_readdata = state_reg.readdata;
  assign link.cmd_valid = state_reg.cmd_valid;
  assign link.cmd_long = state_reg.cmd_long;
  assign link.cmd_frame = state_reg.cmd_frame;
  assign link.cmd_crc = state_reg.cmd_crc;
endmodule : sbcd_bus_controller
`default_nettype wire

// [verif/sbcd_chk.sv]
`default_nettype none
module sbcd_chk (
  input wire logic ref_clk, // clock
  input wire logic resetn, // sync reset, active low
  input wire logic cmd_valid, // frame strobe
  input wire logic cmd_long, // long frame
  input wire logic [15:0] cmd_frame, // command frame
  input wire logic [3:0] cmd_crc, // command crc
  input wire logic rsp_valid, // response strobe
  input wire logic rsp_long, // long response
  input wire logic [15:0] rsp_frame, // response frame
  input wire logic [3:0] rsp_crc // response crc
);
  timeunit 1ns;
  timeprecision 100ps;
  import sbcd_pkg::*;
  logic cmd_valid_reg;
  logic [15:0] cmd_frame_reg;

  // standard polynomial and seed only: enhanced mode would need the live format state
  function automatic logic [3:0] chk_crc(input logic [15:0] b);
    logic [3:0] c;
    logic fb;
    c = STD_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ b[i];
      c = {c[2:0], 1'b0} ^ (fb ? STD_POLY : 4'h0);
    end
    return c;
  endfunction : chk_crc

  always_ff @(posedge ref_clk) begin
    cmd_valid_reg <= cmd_valid;
    cmd_frame_reg <= cmd_frame;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_rsp_one_after: assert property (rsp_valid |-> cmd_valid_reg) else $error("response without command");
  a_rsp_pad_zero: assert property (rsp_valid && rsp_long |-> rsp_frame[11:8] == 4'h0)
    else $error("response pad nibble not zero");
  a_rsp_addr_match: assert property (rsp_valid && rsp_long && cmd_frame_reg[3:0] != SBCD_CMD_INIT
    |-> rsp_frame[15:12] == cmd_frame_reg[7:4]) else $error("response address wrong");
  a_global_silent: assert property (cmd_valid && cmd_frame[7:4] == GLOBAL_ADDR |=> !rsp_valid)
    else $error("answer to global address");
  a_clear_silent: assert property (cmd_valid && cmd_frame[3:0] inside {4'h6, 4'h7, [4'h8:4'h9], [4'hb:4'hf]}
    |=> !rsp_valid) else $error("answer to clear or reserved code");
  a_short_sense_only: assert property (rsp_valid && !rsp_long
    |-> cmd_frame_reg[3:0] inside {SBCD_CMD_SENSE0, SBCD_CMD_SENSE1}) else $error("short answer to other command");
  a_init_echo: assert property (rsp_valid && cmd_frame_reg[3:0] == SBCD_CMD_INIT |-> rsp_frame ==
    {cmd_frame_reg[11:8], 5'h00, cmd_frame_reg[14:13], 1'b0, cmd_frame_reg[11:8]}) else $error("init echo wrong");
  a_ioctl_echo: assert property (rsp_valid && cmd_frame_reg[3:0] == SBCD_CMD_IOCTL |-> rsp_frame[7:0] ==
    {1'b0, cmd_frame_reg[14:12], 1'b0, cmd_frame_reg[10:8]}) else $error("io control echo wrong");
  a_fmt_echo: assert property (rsp_valid && cmd_frame_reg[3:0] == SBCD_CMD_FORMAT
    |-> rsp_frame[7:4] == cmd_frame_reg[15:12]) else $error("format echo wrong");
  a_rsp_crc_long: assert property (rsp_valid && rsp_long |-> rsp_crc == chk_crc(rsp_frame))
    else $error("response crc wrong");
  ////////////////////////////////////////////////////////////////////////////////
  c_long_rsp: cover property (rsp_valid && rsp_long);
  c_short_rsp: cover property (rsp_valid && !rsp_long);
  c_short_cmd: cover property (cmd_valid && !cmd_long);
  c_bad_crc: cover property (cmd_valid && cmd_long && cmd_crc != chk_crc(cmd_frame));
endmodule : sbcd_chk
`default_nettype wire

// [verif/tb.sv]
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sbcd_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [9:0] sin0 = 10'h2b7;
  logic [9:0] sin1 = 10'h1c3;
  logic [2:0] io_in = 3'b101;
  logic [2:0] io_out;
  logic [2:0] io_oe;
  logic up_switch, lo_switch, jit;
  logic [3:0] node_addr;
  int bad_count = 0;
  int compares = 0;

  always #12.5 ref_clk = ~ref_clk;

  sbcd_link_if i_sbcd_link_if ();
  // issue and flag values are arbitrary
  sbcd_sensor_node #(.CHIP_ISSUE(4'h6), .ID_FLAG(1'b1), .SENSE_W(10)) i_sbcd_sensor_node (.ref_clk(ref_clk),
    .resetn(resetn), .link(i_sbcd_link_if), .sensor_input_0(sin0), .sensor_input_1(sin1), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .upper_switch_close(up_switch), .lower_switch_close(lo_switch),
    .clock_jitter_enable(jit), .node_addr(node_addr));
  sbcd_bus_controller i_sbcd_bus_controller (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(i_sbcd_link_if));
  sbcd_chk i_sbcd_chk (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(i_sbcd_link_if.cmd_valid),
    .cmd_long(i_sbcd_link_if.cmd_long), .cmd_frame(i_sbcd_link_if.cmd_frame), .cmd_crc(i_sbcd_link_if.cmd_crc),
    .rsp_valid(i_sbcd_link_if.rsp_valid), .rsp_long(i_sbcd_link_if.rsp_long),
    .rsp_frame(i_sbcd_link_if.rsp_frame), .rsp_crc(i_sbcd_link_if.rsp_crc));
  ////////////////////////////////////////////////////////////////////////////////
  // waitrequest is sampled before the edge, so it never races the edge's own updates
  task automatic av_cycle(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    logic w;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(negedge ref_clk);
      w = avs_waitrequest;
      q = avs_readdata;
      @(posedge ref_clk);
    end while (w !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av_cycle

  task automatic xfer(input logic lng, input logic [15:0] f, input logic got, input logic [15:0] ef);
    logic [31:0] s;
    logic [31:0] r;
    int n;
    av_cycle(1'b0, CTL_CMD_OFS, {15'h0, lng, f}, r);
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 40) begin
      av_cycle(1'b1, CTL_STAT_OFS, 32'h0, s);
      n++;
    end
    `CHK(s[0], 1'b0)
    `CHK(s[1], got)
    if (got) begin
      `CHK(s[3:2], {lng, 1'b0})
      av_cycle(1'b1, CTL_RSP_OFS, 32'h0, r);
      `CHK(r[15:0], ef)
    end
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_init;
    xfer(1'b1, 16'h5530, 1'b1, 16'h5045);
    `CHK({up_switch, lo_switch, jit, node_addr}, {3'b101, 4'h5})
    xfer(1'b1, 16'h2550, 1'b1, 16'h5025);
    `CHK({up_switch, lo_switch, jit}, 3'b010)
    $display("test init done");
  endtask : t_init

  task automatic t_status_sense;
    xfer(1'b1, 16'h0051, 1'b1, 16'h5025);
    io_in <= 3'b010;
    xfer(1'b1, 16'h0051, 1'b1, 16'h5022);
    xfer(1'b1, 16'h0052, 1'b1, 16'h50ad);
    xfer(1'b1, 16'h0055, 1'b1, 16'h5070);
    xfer(1'b0, 16'h0052, 1'b1, 16'h00ad);
    xfer(1'b0, 16'h0054, 1'b0, 16'h0000);
    xfer(1'b1, 16'h0054, 1'b1, 16'h5061);
    $display("test status sense id done");
  endtask : t_status_sense

  task automatic t_ioctl;
    xfer(1'b1, 16'h6353, 1'b1, 16'h5063);
    `CHK(io_oe, 3'b011)
    `CHK(io_out & io_oe, 3'b010)
    $display("test io control done");
  endtask : t_ioctl

  task automatic t_format;
    xfer(1'b1, 16'hda5a, 1'b1, 16'h50da);
    xfer(1'b1, 16'h505a, 1'b1, 16'h505a);
    xfer(1'b1, 16'hd75a, 1'b1, 16'h50da);
    xfer(1'b1, 16'h9f5a, 1'b1, 16'h5090);
    xfer(1'b1, 16'h205a, 1'b1, 16'h502a);
    xfer(1'b1, 16'h0057, 1'b0, 16'h0000);
    xfer(1'b1, 16'h505a, 1'b1, 16'h5058);
    // enhanced mode with default poly and seed keeps the crc unchanged
    xfer(1'b1, 16'hff5a, 1'b1, 16'h50ff);
    xfer(1'b1, 16'hda5a, 1'b1, 16'h50d8);
    xfer(1'b1, 16'hf05a, 1'b1, 16'h50f0);
    $display("test format done");
  endtask : t_format

  task automatic t_silent;
    logic [3:0] codes [8] = '{4'h6, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, {8'h00, 4'h5, codes[i]}, 1'b0, 16'h0000);
    end
    xfer(1'b1, 16'h0001, 1'b0, 16'h0000);
    xfer(1'b1, 16'h0091, 1'b0, 16'h0000);
    xfer(1'b1, 16'h0703, 1'b0, 16'h0000);
    `CHK(io_oe, 3'b111)
    $display("test silent commands done");
  endtask : t_silent

  task automatic t_regs;
    logic [31:0] q;
    av_cycle(1'b1, CTL_CFG_OFS, 32'h0, q);
    `CHK(q, 32'h0000_08a1)
    av_cycle(1'b1, 4'h2, 32'h0, q);
    `CHK(q, 32'h0)
    // a wrong seed on the controller side corrupts every command crc
    av_cycle(1'b0, CTL_CFG_OFS, 32'hffff_f8b1, q);
    av_cycle(1'b1, CTL_CFG_OFS, 32'h0, q);
    `CHK(q, 32'h0000_08b1)
    xfer(1'b1, 16'h0051, 1'b0, 16'h0000);
    av_cycle(1'b0, CTL_CFG_OFS, 32'h0000_08a1, q);
    $display("test registers and crc done");
  endtask : t_regs

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    t_init();
    t_status_sense();
    t_ioctl();
    t_format();
    t_silent();
    t_regs();
    tally_and_finish();
  end

  initial begin
    repeat (8000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
